// ==== chg_host_model.sv ====
// Host processor model driving the charger serial command port
`timescale 1ns/1ps
`default_nettype none
module chg_host_model #(
   parameter int ADC_CLKS = 2
) (
   // Serial pins
   output var  logic cs_n_o,
   output var  logic sclk_o,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i,
   output var  logic sdi_o
);
   ////////////////////////////////////////////////////////////////////
   // Idle levels, serial clock stands low outside frames
   initial
   begin
      cs_n_o = 1'h1;
      sclk_o = 1'h0;
      sdi_o  = 1'h0;
   end

   ////////////////////////////////////////////////////////////////////
   // One frame: select, leading zeros, command, then read the answer
   task automatic xfer(input logic [21:0] cmd, input int nz,
                       input int ncmd, input int nextra, input int nout,
                       output logic [27:0] rx, output logic oe_seen);
      rx      = '0;
      oe_seen = 1'h0;
      cs_n_o  = 1'h0;
      #1000;
      for (int i = 0; i < nz + ncmd; i++)
      begin
         sdi_o = (i < nz) ? 1'h0 : cmd[i-nz];
         #62.5 sclk_o = 1'h1;
         oe_seen = oe_seen | sdo_oe_i;
         #62.5 sclk_o = 1'h0;
      end
      sdi_o = ~sdi_o;
      for (int j = 1; j <= nextra; j++)
      begin
         #62.5 sclk_o = 1'h1;
         if (j >= ADC_CLKS && j - ADC_CLKS < nout)
            rx = {rx[26:0], sdo_i};
         #62.5 sclk_o = 1'h0;
      end
   endtask

   // Deselect ends the frame; data line no longer holds its value
   task automatic deselect();
      cs_n_o = 1'h1;
      sdi_o  = ~sdi_o;
      #1000;
   endtask
endmodule // chg_host_model
`default_nettype wire

// ==== chg_pkg.sv ====
// Constants, types and field layout of the charger command front end
`default_nettype none
package chg_pkg;
   // Word sizes
   localparam int CMD_BITS   = 22;
   localparam int ADC_BITS   = 10;
   localparam int STAT_BITS  = 8;
   localparam int TX_BITS    = 2 * ADC_BITS + STAT_BITS;
   localparam int LEN_MSB    = ADC_BITS + STAT_BITS;
   localparam int LEN_BOTH   = 2 * ADC_BITS + STAT_BITS;

   // Bit positions (bit number minus one) inside the command word
   localparam int IDX_START  = 0;
   localparam int IDX_OP_LO  = 1;
   localparam int IDX_OP_HI  = 2;
   localparam int IDX_LAST   = CMD_BITS - 1;

   // Power-up value of the command word
   localparam logic [CMD_BITS-1:0] CMD_RESET = 22'h000000;

   // Timing: PWM rate derived from the system clock
   localparam int CLK_FREQ_KHZ = 125000;
   localparam int PWM_FREQ_KHZ = 111;
   localparam int PWM_PERIOD   = CLK_FREQ_KHZ / PWM_FREQ_KHZ;
   localparam int SLOTS        = 16;
   localparam logic [2:0] DUTY_MAX = 3'h4;

   // Operating modes, second mode bit is the high bit
   typedef enum logic [1:0] {
      MODE_IDLE   = 2'h0,
      MODE_DISCH  = 2'h1,
      MODE_CHARGE = 2'h2,
      MODE_GAS    = 2'h3
   } chg_mode_e;

   // Serial sequencer states
   typedef enum logic [2:0] {
      ST_OFF  = 3'h0,
      ST_HUNT = 3'h1,
      ST_CMD  = 3'h2,
      ST_CONV = 3'h3,
      ST_OUT  = 3'h4,
      ST_DONE = 3'h5
   } chg_state_e;

   // Command word, bit 1 at the bottom
   typedef struct packed {
      logic [1:0] ref_level_sel;
      logic [2:0] timeout_sel;
      logic       failsafe_clear_bit;
      logic [2:0] duty_sel;
      logic       power_down_bit;
      logic [3:0] ratio_sel;
      logic [2:0] adc_input_sel;
      logic       output_order_sel;
      logic       single_vs_diff_sel;
      logic [1:0] op_sel;
      logic       start;
   } chg_cmd_s;
endpackage
`default_nettype wire

// ==== chg_serial_ctrl.sv ====
// Serial command interpreter and mode controller of the charger
//
// Function
// - Each transaction carries a 22-bit command word
// - Command word clears to zero at reset
// - Leading zeros ignored until the start bit
// - Fixed bit order of the command fields
// - Mode bits: second high, first low
// - Mode bits take effect as each arrives
// - Serial input sampled on clock rise
// - Serial output changes on clock fall
// - Output silent while command bits arrive
// - One conversion, then result and status out
// - Power-down stops analog, keeps serial logic
// - Idle disables PWM and discharge outputs
// - Discharge output high only in discharge
// - Four-bit divider ratio, 1/1 to 1/16
// - Divider off in shutdown and gas gauge
// - Charge mode runs 111 kHz PWM loop
// - Gas gauge routes sense signal to ADC
// - Faults monitored in discharge and charge
// - Order bit picks MSB-only or MSB-then-LSB
// - Fail-safe clear bit self-clears at deselect
// - Status word is eight bits long
`timescale 1ns/1ps
`default_nettype none
module chg_serial_ctrl #(
   parameter int ADC_CLKS = 2
) (
   // Clock, reset, enable
   input  wire logic                           mclk_i,
   input  wire logic                           nrst_i,
   input  wire logic                           ce_i,
   // Serial pins
   input  wire logic                           cs_n_i,
   input  wire logic                           sclk_i,
   input  wire logic                           sdi_i,
   output var  logic                           sdo_o,
   output var  logic                           sdo_oe_o,
   // Analog side
   input  wire logic [chg_pkg::ADC_BITS-1:0]   adc_result_i,
   input  wire logic [chg_pkg::STAT_BITS-1:0]  fault_i,
   input  wire logic                           sense_over_i,
   output var  logic                           adc_start_o,
   output var  logic                           analog_en_o,
   output var  logic                           div_connect_o,
   output var  logic                           gas_route_o,
   output var  logic                           dis_o,
   output var  logic                           fet_gate_drive_o,
   output var  logic                           failsafe_clear_o,
   output var  chg_pkg::chg_cmd_s              cmd_o
);

   // Elaboration check, the conversion counter is four bits wide
   if (ADC_CLKS < 1 || ADC_CLKS > 16) begin : g_bad_clks
      $error("ADC_CLKS must be between one and sixteen");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detect
   logic [2:0] sclk_sync;
   logic [1:0] cs_sync;
   logic [1:0] sdi_sync;
   logic [1:0] sense_sync;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_high;
   logic       sdi_bit;

   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         sclk_sync  <= 3'h0;
         cs_sync    <= 2'h3;
         sdi_sync   <= 2'h0;
         sense_sync <= 2'h0;
      end
      else if (ce_i)
      begin
         sclk_sync  <= {sclk_sync[1:0], sclk_i};
         cs_sync    <= {cs_sync[0], cs_n_i};
         sdi_sync   <= {sdi_sync[0], sdi_i};
         sense_sync <= {sense_sync[0], sense_over_i};
      end
   end

   assign sclk_rise = ce_i && sclk_sync[1] && !sclk_sync[2];
   assign sclk_fall = ce_i && !sclk_sync[1] && sclk_sync[2];
   assign cs_high   = cs_sync[1];
   assign sdi_bit   = sdi_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // Serial sequencer
   chg_pkg::chg_state_e                  state;
   logic [4:0]                           bit_cnt;
   logic [4:0]                           out_cnt;
   logic [4:0]                           out_len;
   logic [3:0]                           conv_cnt;
   logic [chg_pkg::CMD_BITS-2:0]         shadow;
   logic [chg_pkg::TX_BITS-1:0]          tx;
   logic [chg_pkg::STAT_BITS-1:0]        status;
   logic                                 commit;

   assign commit = (state == chg_pkg::ST_CMD) && sclk_rise && !cs_high
                   && (bit_cnt == 5'(chg_pkg::IDX_LAST));

   // Result bit-reversed for the LSB-first tail
   logic [chg_pkg::ADC_BITS-1:0]         adc_rev;
   for (genvar k = 0; k < chg_pkg::ADC_BITS; k++)
   begin : g_rev
      assign adc_rev[k] = adc_result_i[chg_pkg::ADC_BITS-1-k];
   end

   // State, counters and shift registers
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         state    <= chg_pkg::ST_OFF;
         bit_cnt  <= 5'h00;
         out_cnt  <= 5'h00;
         out_len  <= 5'h00;
         conv_cnt <= 4'h0;
         shadow   <= '0;
         tx       <= '0;
         sdo_o    <= 1'b0;
         sdo_oe_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (cs_high)
         begin
            state    <= chg_pkg::ST_OFF;
            sdo_oe_o <= 1'b0;
            sdo_o    <= 1'b0;
         end
         else
         begin
            case (state)
               chg_pkg::ST_OFF:
                  state <= chg_pkg::ST_HUNT;
               chg_pkg::ST_HUNT:
                  if (sclk_rise && sdi_bit)
                  begin
                     shadow[chg_pkg::IDX_START] <= 1'b1;
                     bit_cnt <= 5'h01;
                     state   <= chg_pkg::ST_CMD;
                  end
               chg_pkg::ST_CMD:
                  if (commit)
                  begin
                     conv_cnt <= 4'h0;
                     state    <= chg_pkg::ST_CONV;
                  end
                  else if (sclk_rise)
                  begin
                     shadow[bit_cnt] <= sdi_bit;
                     bit_cnt <= bit_cnt + 5'h01;
                  end
               chg_pkg::ST_CONV:
                  if (sclk_fall)
                  begin
                     if (conv_cnt == 4'(ADC_CLKS - 1))
                     begin
                        if (cmd_o.output_order_sel)
                        begin
                           tx <= {adc_result_i, status,
                                  {chg_pkg::ADC_BITS{1'b0}}};
                           out_len <= 5'(chg_pkg::LEN_MSB);
                        end
                        else
                        begin
                           tx <= {adc_result_i, adc_rev, status};
                           out_len <= 5'(chg_pkg::LEN_BOTH);
                        end
                        sdo_o    <= adc_result_i[chg_pkg::ADC_BITS-1];
                        sdo_oe_o <= 1'b1;
                        out_cnt  <= 5'h00;
                        state    <= chg_pkg::ST_OUT;
                     end
                     else
                        conv_cnt <= conv_cnt + 4'h1;
                  end
               chg_pkg::ST_OUT:
                  if (sclk_fall)
                  begin
                     if (out_cnt == out_len - 5'h01)
                     begin
                        sdo_o <= 1'b0;
                        state <= chg_pkg::ST_DONE;
                     end
                     else
                     begin
                        tx      <= {tx[chg_pkg::TX_BITS-2:0], 1'b0};
                        sdo_o   <= tx[chg_pkg::TX_BITS-2];
                        out_cnt <= out_cnt + 5'h01;
                     end
                  end
               chg_pkg::ST_DONE:
                  state <= chg_pkg::ST_DONE;
               default:
                  state <= chg_pkg::ST_OFF;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command word register
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         cmd_o <= chg_pkg::chg_cmd_s'(chg_pkg::CMD_RESET);
      else if (ce_i)
      begin
         if (cs_high)
            cmd_o.failsafe_clear_bit <= 1'b0;
         else if (commit)
            cmd_o <= chg_pkg::chg_cmd_s'({sdi_bit, shadow});
         else if ((state == chg_pkg::ST_CMD) && sclk_rise)
         begin
            if (bit_cnt == 5'(chg_pkg::IDX_OP_LO))
               cmd_o.op_sel[0] <= sdi_bit;
            if (bit_cnt == 5'(chg_pkg::IDX_OP_HI))
               cmd_o.op_sel[1] <= sdi_bit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode decode into registered controls
   chg_pkg::chg_mode_e mode;
   logic               awake;
   logic               dis_want;
   assign mode     = chg_pkg::chg_mode_e'(cmd_o.op_sel);
   assign awake    = !cmd_o.power_down_bit;
   assign dis_want = awake && (mode == chg_pkg::MODE_DISCH);

   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         analog_en_o      <= 1'b1;
         div_connect_o    <= 1'b1;
         gas_route_o      <= 1'b0;
         dis_o            <= 1'b0;
         adc_start_o      <= 1'b0;
         failsafe_clear_o <= 1'b0;
      end
      else if (ce_i)
      begin
         analog_en_o      <= awake;
         div_connect_o    <= awake && (mode != chg_pkg::MODE_GAS);
         gas_route_o      <= awake && (mode == chg_pkg::MODE_GAS);
         dis_o            <= dis_want;
         adc_start_o      <= commit;
         failsafe_clear_o <= cmd_o.failsafe_clear_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fail-safe status latches, one per bit
   logic [chg_pkg::STAT_BITS-1:0] fault_s1;
   logic [chg_pkg::STAT_BITS-1:0] fault_s2;
   logic                          watching;
   assign watching = awake && ((mode == chg_pkg::MODE_DISCH)
                               || (mode == chg_pkg::MODE_CHARGE));

   for (genvar i = 0; i < chg_pkg::STAT_BITS; i++) begin : g_stat
      always_ff @(posedge mclk_i)
      begin
         if (!nrst_i)
         begin
            fault_s1[i] <= 1'b0;
            fault_s2[i] <= 1'b0;
            status[i]   <= 1'b0;
         end
         else if (ce_i)
         begin
            fault_s1[i] <= fault_i[i];
            fault_s2[i] <= fault_s1[i];
            if (watching && fault_s2[i])
               status[i] <= 1'b1;
            else if (cmd_o.failsafe_clear_bit)
               status[i] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Charge PWM loop with duty slots
   logic [10:0] pwm_cnt;
   logic [3:0]  slot;
   logic        charging;
   logic        slot_on;
   assign charging = awake && (mode == chg_pkg::MODE_CHARGE);
   assign slot_on  = (cmd_o.duty_sel <= chg_pkg::DUTY_MAX)
                     && ({1'b0, slot} < (5'h01 << cmd_o.duty_sel));

   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         pwm_cnt          <= 11'h000;
         slot             <= 4'h0;
         fet_gate_drive_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (!charging)
         begin
            pwm_cnt          <= 11'h000;
            slot             <= 4'h0;
            fet_gate_drive_o <= 1'b0;
         end
         else if (pwm_cnt == 11'(chg_pkg::PWM_PERIOD - 1))
         begin
            pwm_cnt          <= 11'h000;
            slot             <= slot + 4'h1;
            fet_gate_drive_o <= 1'b0;
         end
         else
         begin
            pwm_cnt <= pwm_cnt + 11'h001;
            if (pwm_cnt == 11'h000)
               fet_gate_drive_o <= slot_on && !sense_sync[1];
            else if (sense_sync[1])
               fet_gate_drive_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   chk_cs_release: assert property (cs_high && ce_i |=> !sdo_oe_o)
      else $error("output still driven after deselect");
   chk_rx_quiet: assert property (state inside {chg_pkg::ST_HUNT,
      chg_pkg::ST_CMD, chg_pkg::ST_CONV} |-> !sdo_oe_o)
      else $error("output driven during command");
   chk_start_hunt: assert property ((state == chg_pkg::ST_HUNT) && sclk_rise
      && !sdi_bit && !cs_high |=> state == chg_pkg::ST_HUNT)
      else $error("zero taken as start bit");
   chk_mode_early: assert property ((state == chg_pkg::ST_CMD) && sclk_rise
      && !cs_high && (bit_cnt == 5'h01) |=> cmd_o.op_sel[0] == $past(sdi_bit))
      else $error("low mode bit not applied at once");
   chk_dis_mode: assert property ($past(ce_i) && $past(nrst_i)
      |-> dis_o == $past(dis_want))
      else $error("discharge output wrong for mode");
   chk_gate_idle: assert property (!charging && ce_i |=> !fet_gate_drive_o)
      else $error("gate driven outside charge mode");
   chk_div_gas: assert property (ce_i && awake && mode == chg_pkg::MODE_GAS
      |=> !div_connect_o && gas_route_o)
      else $error("divider connected in gas gauge");
   chk_failsafe_clear_bit_drop: assert property (cs_high && ce_i
      |=> !cmd_o.failsafe_clear_bit)
      else $error("fail-safe clear bit not dropped");
   chk_adc_pulse: assert property (commit |=> adc_start_o ##1 !adc_start_o
      || commit)
      else $error("conversion start not one pulse");
   chk_first_out: assert property ((state == chg_pkg::ST_CONV)
      ##1 (state == chg_pkg::ST_OUT) |-> sdo_oe_o
      && sdo_o == tx[chg_pkg::TX_BITS-1])
      else $error("first output bit is not result MSB");

endmodule // chg_serial_ctrl
`default_nettype wire

// ==== chg_serial_ctrl_tb_top.sv ====
// Self-checking testbench of the charger serial command front end
`timescale 1ns/1ps
`default_nettype none
module chg_serial_ctrl_tb_top;
   localparam int ADC_CLKS = 2;
   // Design side signals
   logic              mclk    = 1'h0;
   logic              nrst    = 1'h0;
   logic [9:0]        adc_res = 10'h2B5;
   logic [7:0]        fault   = 8'h00;
   logic              cs_n, sclk, sdi, sdo, sdo_oe;
   logic              analog_en, div_conn, gas_route, dis, gate, fs_clr;
   chg_pkg::chg_cmd_s cmd;
   logic              ce      = 1'h1;
   logic              sense   = 1'h0;
   logic              adc_go;
   int                starts  = 0;
   int                failures = 0;
   int                n_checks = 0;

   ////////////////////////////////////////////////////////////////////
   // Clock and instances
   always #4 mclk = ~mclk;

   // Count conversion start pulses mid-cycle
   always @(negedge mclk)
   begin
      if (adc_go === 1'h1)
         starts++;
   end

   chg_serial_ctrl #(.ADC_CLKS(ADC_CLKS)) chg_serial_ctrl_inst (
      .mclk_i(mclk), .nrst_i(nrst), .ce_i(ce), .cs_n_i(cs_n),
      .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
      .adc_result_i(adc_res), .fault_i(fault), .sense_over_i(sense),
      .adc_start_o(adc_go), .analog_en_o(analog_en),
      .div_connect_o(div_conn),
      .gas_route_o(gas_route), .dis_o(dis), .fet_gate_drive_o(gate),
      .failsafe_clear_o(fs_clr), .cmd_o(cmd));

   chg_host_model #(.ADC_CLKS(ADC_CLKS)) chg_host_model_inst (
      .cs_n_o(cs_n), .sclk_o(sclk), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
      .sdi_o(sdi));

   ////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %0h expected %0h",
                  $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (failures == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic settle();
      repeat (8) @(posedge mclk);
      #1;
   endtask

   function automatic chg_pkg::chg_cmd_s mk(input logic [1:0] op,
      input logic ord, input logic [3:0] rat, input logic pd,
      input logic fs);
      chg_pkg::chg_cmd_s c;
      c = '0;
      c.start              = 1'h1;
      c.op_sel             = op;
      c.output_order_sel   = ord;
      c.ratio_sel          = rat;
      c.power_down_bit     = pd;
      c.failsafe_clear_bit = fs;
      c.single_vs_diff_sel = 1'h1;
      c.adc_input_sel      = 3'h3;
      c.duty_sel           = 3'h4;
      c.timeout_sel        = 3'h5;
      c.ref_level_sel      = 2'h2;
      return c;
   endfunction

   function automatic logic [9:0] rev(input logic [9:0] v);
      for (int i = 0; i < 10; i++)
         rev[i] = v[9-i];
   endfunction

   // Full frame with the clock count the output order needs
   task automatic frame(input chg_pkg::chg_cmd_s c, input int nz,
                        output logic [27:0] rx, output logic oe);
      chg_host_model_inst.xfer(c, nz, 22, c.output_order_sel ? 21 : 30,
                               c.output_order_sel ? 18 : 28, rx, oe);
      settle();
   endtask

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      check(cmd, 22'h000000);
      check({sdo_oe, dis, gate, gas_route, analog_en, div_conn}, 6'h03);
   endtask

   task automatic t_discharge();
      chg_pkg::chg_cmd_s c;
      logic [27:0] rx;
      logic oe;
      c = mk(chg_pkg::MODE_DISCH, 1'h1, 4'hF, 1'h0, 1'h0);
      fault = 8'h05;
      frame(c, 3, rx, oe);
      check(oe, 1'h0);
      check(starts, 1);
      check(rx[17:0], {10'h2B5, 8'h05});
      check({dis, gate, div_conn, gas_route}, 4'hA);
      chg_host_model_inst.deselect();
      settle();
      fault = 8'h00;
      check(cmd, c);
      check(sdo_oe, 1'h0);
   endtask

   task automatic t_gas();
      chg_pkg::chg_cmd_s c;
      logic [27:0] rx;
      logic oe;
      c = mk(chg_pkg::MODE_GAS, 1'h0, 4'h0, 1'h0, 1'h0);
      adc_res = 10'h1C3;
      frame(c, 0, rx, oe);
      check(rx, {10'h1C3, rev(10'h1C3), 8'h05});
      check({dis, gate, div_conn, gas_route}, 4'h1);
      chg_host_model_inst.deselect();
      settle();
      check(cmd, c);
   endtask

   task automatic t_charge();
      chg_pkg::chg_cmd_s c;
      logic [27:0] rx;
      logic oe;
      c = mk(chg_pkg::MODE_CHARGE, 1'h1, 4'h9, 1'h0, 1'h1);
      frame(c, 1, rx, oe);
      check(fs_clr, 1'h1);
      check(rx[7:0], 8'h00);
      check({dis, div_conn, gas_route}, 3'h2);
      for (int i = 0; i < 1200 && gate !== 1'h1; i++)
      begin
         @(posedge mclk);
         #1;
      end
      check(gate, 1'h1);
      sense = 1'h1;
      settle();
      check(gate, 1'h0);
      sense = 1'h0;
      ce = 1'h0;
      chg_host_model_inst.deselect();
      settle();
      check(fs_clr, 1'h1);
      ce = 1'h1;
      settle();
      c.failsafe_clear_bit = 1'h0;
      check(fs_clr, 1'h0);
      check(cmd, c);
   endtask

   task automatic t_abort();
      logic [27:0] rx;
      logic oe;
      chg_host_model_inst.xfer(mk(chg_pkg::MODE_DISCH, 1'h1, 4'h0, 1'h0,
                               1'h0), 2, 3, 0, 0, rx, oe);
      settle();
      check(cmd.op_sel, chg_pkg::MODE_DISCH);
      check(cmd.ratio_sel, 4'h9);
      check({dis, gate}, 2'h2);
      check(starts, 3);
      chg_host_model_inst.deselect();
      settle();
      check(sdo_oe, 1'h0);
   endtask

   task automatic t_idle_power();
      chg_pkg::chg_cmd_s c;
      logic [27:0] rx;
      logic oe;
      c = mk(chg_pkg::MODE_IDLE, 1'h1, 4'h3, 1'h0, 1'h0);
      frame(c, 0, rx, oe);
      check({dis, gate, gas_route, analog_en, div_conn}, 5'h03);
      chg_host_model_inst.deselect();
      c = mk(chg_pkg::MODE_DISCH, 1'h1, 4'h5, 1'h1, 1'h0);
      frame(c, 0, rx, oe);
      check(rx[17:0], {10'h1C3, 8'h00});
      check({analog_en, div_conn, dis, gate, gas_route}, 5'h00);
      chg_host_model_inst.deselect();
      settle();
      check(cmd, c);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Watchdog against a hang
   initial
   begin
      repeat (100000) @(posedge mclk);
      failures++;
      end_of_test();
   end

   // Main sequence
   initial
   begin
      repeat (16) @(posedge mclk);
      #1 nrst = 1'h1;
      repeat (4) @(posedge mclk);
      #1;
      t_reset();
      t_discharge();
      t_gas();
      t_charge();
      t_abort();
      t_idle_power();
      end_of_test();
   end
endmodule // chg_serial_ctrl_tb_top
`default_nettype wire
